// File: hw/flpe_top.sv
// flash program/erase sequencer with block protection, register front end
//
// Contract
// - high voltage sets only after selection sequence
// - high voltage bit drives pump and array
// - mass bit picks whole-array or page erase
// - program and erase never both set
// - page erase covers one aligned 512-byte page
// - page erase never touches vector region
// - first write after program select picks row
// - programming stays within one 64-byte row
// - protected target refuses high voltage
// - option byte and vectors protected except from whole-array erase
// - protect bits 7:1 give address 15:9
// - bit 0 only marks the all-ones value
// - low values protect all, FC-FE top only
// - erased cells read one, programmed zero
module flpe_top
    import flpe_pkg::*;
#(
    parameter int PROG_GAP_CYCLES = PROG_MAX_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire logic i_flash_wr,
    input wire logic [15:0] i_flash_addr,
    input wire logic [7:0] i_flash_wdata,
    output logic o_pump_on,
    output logic o_array_hv,
    output logic o_prog_strobe,
    output logic [15:0] o_prog_addr,
    output logic [7:0] o_prog_data,
    output logic o_erase_run,
    output logic o_erase_mass,
    output logic [6:0] o_erase_page,
    output logic [7:0] o_erase_value
);
    // control and protect state
    logic program_select_reg;
    logic erase_select_reg;
    logic mass_select_reg;
    logic high_voltage_enable_reg;
    logic [7:0] protect_start_bits_reg;
    logic refused_reg;
    logic overrun_reg;
    logic interlock_reg;
    logic [GAP_CNT_W-1:0] gap_cnt_reg;
    logic gap_armed_reg;

    // output flops
    logic [7:0] rdata_reg;
    logic pump_reg;
    logic array_hv_reg;
    logic prog_strobe_reg;
    logic [15:0] prog_addr_reg;
    logic [7:0] prog_data_reg;
    logic erase_run_reg;
    logic erase_mass_reg;
    logic [6:0] erase_page_reg;
    logic [7:0] erase_value_reg;

    // decode
    wire logic wr_control;
    wire logic wr_protect;
    wire logic wr_status;
    wire logic both_req;
    wire logic sel_any;
    wire logic sel_hold;
    wire logic mass_next;
    wire logic target_latched;
    wire logic [15:0] target_addr;
    wire logic in_row;
    wire logic [15:0] protect_start;
    wire logic target_protected;
    wire logic hv_allowed;
    wire logic hv_set_req;
    wire logic hv_refuse;
    wire logic pgm_next;
    wire logic erase_next;
    wire logic high_voltage_enable_next;
    wire logic prog_hit;
    wire logic erase_active;
    wire logic vector_page_hit;
    wire logic gap_expired;
    wire logic [7:0] control_view;
    wire logic [7:0] status_view;
    wire logic [7:0] rdata_next;

    assign wr_control = i_reg_wr && (i_reg_addr == REG_CONTROL);
    assign wr_protect = i_reg_wr && (i_reg_addr == REG_PROTECT);
    assign wr_status = i_reg_wr && (i_reg_addr == REG_STATUS);

    assign sel_any = program_select_reg || erase_select_reg;

    // a write that moves the selection drops the old target, so a page
    // erase never runs on a row latched for programming
    assign sel_hold = (pgm_next == program_select_reg) &&
        (erase_next == erase_select_reg);
    assign mass_next = wr_control ? i_reg_wdata[CTL_MASS_BIT] :
        mass_select_reg;

    flpe_target u_target (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_select_any(sel_any && sel_hold),
        .i_flash_wr(i_flash_wr),
        .i_flash_addr(i_flash_addr),
        .o_latched(target_latched),
        .o_target(target_addr),
        .o_in_row(in_row)
    );

    flpe_protect u_protect (
        .i_protect_start_bits(protect_start_bits_reg),
        .i_target(target_addr),
        .i_mass(erase_select_reg && mass_select_reg),
        .o_start(protect_start),
        .o_target_protected(target_protected)
    );

    // a write asking for both selections is dropped whole for those bits
    assign both_req = wr_control && i_reg_wdata[CTL_PGM_BIT] &&
        i_reg_wdata[CTL_ERASE_BIT];
    assign pgm_next = (wr_control && !both_req) ?
        i_reg_wdata[CTL_PGM_BIT] : program_select_reg;
    assign erase_next = (wr_control && !both_req) ?
        i_reg_wdata[CTL_ERASE_BIT] : erase_select_reg;

    // selection in force and left alone by this write, dummy write latched
    // and target unprotected; a mode change here skips the checked steps
    assign hv_allowed = (program_select_reg ^ erase_select_reg) &&
        sel_hold && (mass_next == mass_select_reg) &&
        target_latched && !target_protected;
    assign hv_set_req = wr_control && i_reg_wdata[CTL_HIGH_VOLTAGE_ENABLE_BIT] &&
        !high_voltage_enable_reg;
    assign hv_refuse = hv_set_req && !hv_allowed;
    assign high_voltage_enable_next = !wr_control ? high_voltage_enable_reg :
        (i_reg_wdata[CTL_HIGH_VOLTAGE_ENABLE_BIT] &&
         (high_voltage_enable_reg || hv_allowed));

    // bytes outside the latched row, or once the row is guarded by a
    // later protect write, are ignored
    assign prog_hit = program_select_reg && high_voltage_enable_reg &&
        i_flash_wr && in_row && !target_protected;

    assign vector_page_hit = (target_addr[15:PAGE_LSB] == VECTOR_PAGE);
    // protection is rechecked live: a mass or protect write made while
    // high voltage is on must not widen the erase into a guarded range
    assign erase_active = erase_select_reg && high_voltage_enable_reg &&
        target_latched && !target_protected &&
        (mass_select_reg || !vector_page_hit);

    // watches the byte gap the software must keep short
    assign gap_expired = gap_armed_reg &&
        (gap_cnt_reg == GAP_CNT_W'(PROG_GAP_CYCLES));

    assign control_view = {4'h0, high_voltage_enable_reg, mass_select_reg,
        erase_select_reg, program_select_reg};
    assign status_view = {3'h0, interlock_reg, overrun_reg, refused_reg,
        target_protected, target_latched};

    assign rdata_next =
        (i_reg_addr == REG_CONTROL) ? control_view :
        (i_reg_addr == REG_PROTECT) ? protect_start_bits_reg :
        (i_reg_addr == REG_STATUS) ? status_view :
        (i_reg_addr == REG_TARGET_HI) ? target_addr[15:8] :
        (i_reg_addr == REG_TARGET_LO) ? target_addr[7:0] :
        8'h00;

    // control register
    // high voltage may outlive the selection; clearing it is never refused
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            program_select_reg <= 1'b0;
            erase_select_reg <= 1'b0;
            mass_select_reg <= 1'b0;
            high_voltage_enable_reg <= 1'b0;
        end else begin
            program_select_reg <= pgm_next;
            erase_select_reg <= erase_next;
            high_voltage_enable_reg <= high_voltage_enable_next;
            if (wr_control) begin
                mass_select_reg <= i_reg_wdata[CTL_MASS_BIT];
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            protect_start_bits_reg <= PROTECT_RESET;
        end else if (wr_protect) begin
            protect_start_bits_reg <= i_reg_wdata;
        end
    end

    // sticky status: write one to clear, a new event wins over the clear
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            refused_reg <= 1'b0;
            overrun_reg <= 1'b0;
            interlock_reg <= 1'b0;
        end else begin
            refused_reg <= hv_refuse ||
                (refused_reg && !(wr_status &&
                 i_reg_wdata[STS_REFUSED_BIT]));
            overrun_reg <= gap_expired ||
                (overrun_reg && !(wr_status &&
                 i_reg_wdata[STS_OVERRUN_BIT]));
            interlock_reg <= both_req ||
                (interlock_reg && !(wr_status &&
                 i_reg_wdata[STS_INTERLOCK_BIT]));
        end
    end

    // byte gap counter, armed by each programmed byte
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            gap_cnt_reg <= '0;
            gap_armed_reg <= 1'b0;
        end else if (prog_hit) begin
            gap_cnt_reg <= '0;
            gap_armed_reg <= 1'b1;
        end else if (!program_select_reg || gap_expired) begin
            gap_armed_reg <= 1'b0;
        end else if (gap_armed_reg) begin
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
        end
    end

    // pump and array drive follow the enable bit
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pump_reg <= 1'b0;
            array_hv_reg <= 1'b0;
        end else begin
            pump_reg <= high_voltage_enable_next;
            array_hv_reg <= high_voltage_enable_next;
        end
    end

    // programming byte strobe, one cycle per accepted write
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            prog_strobe_reg <= 1'b0;
            prog_addr_reg <= TARGET_RESET;
            prog_data_reg <= 8'h00;
        end else begin
            prog_strobe_reg <= prog_hit;
            if (prog_hit) begin
                prog_addr_reg <= i_flash_addr;
                prog_data_reg <= i_flash_wdata;
            end
        end
    end

    // erase drive: whole array or the latched page, cells go to ones
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            erase_run_reg <= 1'b0;
            erase_mass_reg <= 1'b0;
            erase_page_reg <= 7'h00;
            erase_value_reg <= 8'h00;
        end else begin
            erase_run_reg <= erase_active;
            erase_mass_reg <= mass_select_reg;
            erase_page_reg <= target_addr[15:PAGE_LSB];
            erase_value_reg <= erase_active ? ERASED_BYTE : 8'h00;
        end
    end

    // read data valid the cycle after the read strobe only
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rdata_reg <= 8'h00;
        end else if (i_reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_pump_on = pump_reg;
    assign o_array_hv = array_hv_reg;
    assign o_prog_strobe = prog_strobe_reg;
    assign o_prog_addr = prog_addr_reg;
    assign o_prog_data = prog_data_reg;
    assign o_erase_run = erase_run_reg;
    assign o_erase_mass = erase_mass_reg;
    assign o_erase_page = erase_page_reg;
    assign o_erase_value = erase_value_reg;
endmodule : flpe_top

// File: hw/flpe_pkg.sv
// constants shared by the flash program/erase/protect sequencer
package flpe_pkg;
    localparam int DATA_W = 8;
    localparam int REG_ADDR_W = 8;
    localparam int FLASH_ADDR_W = 16;

    // register offsets
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_PROTECT = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_TARGET_HI = 8'h03;
    localparam logic [7:0] REG_TARGET_LO = 8'h04;

    // flash_control fields
    localparam int CTL_PGM_BIT = 0;
    localparam int CTL_ERASE_BIT = 1;
    localparam int CTL_MASS_BIT = 2;
    localparam int CTL_HIGH_VOLTAGE_ENABLE_BIT = 3;

    // status fields
    localparam int STS_LATCHED_BIT = 0;
    localparam int STS_PROTECTED_BIT = 1;
    localparam int STS_REFUSED_BIT = 2;
    localparam int STS_OVERRUN_BIT = 3;
    localparam int STS_INTERLOCK_BIT = 4;

    // reset values
    localparam logic [7:0] PROTECT_RESET = 8'h00;
    localparam logic [15:0] TARGET_RESET = 16'h0000;

    // array geometry
    localparam int PAGE_LSB = 9;
    localparam int ROW_LSB = 6;
    localparam logic [6:0] VECTOR_PAGE = 7'h7F;
    localparam logic [15:0] ALWAYS_PROT_START = 16'hFFCF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // protect register decode points
    localparam logic [7:0] PROTECT_NONE = 8'hFF;
    localparam logic [7:0] PROTECT_ALL_MAX = 8'h09;
    localparam logic [7:0] PROTECT_TOP_MIN = 8'hFC;
    localparam logic [7:0] PROTECT_TOP_MAX = 8'hFE;

    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_PROG_MAX_NS = 40000;
    localparam int PROG_MAX_CYCLES = T_PROG_MAX_NS / CLK_PERIOD_NS;
    localparam int GAP_CNT_W = 16;
endpackage : flpe_pkg

// File: hw/flpe_protect.sv
// protect boundary decode and target protection check
module flpe_protect
    import flpe_pkg::*;
(
    input wire logic [7:0] i_protect_start_bits,
    input wire logic [15:0] i_target,
    input wire logic i_mass,
    output logic [15:0] o_start,
    output logic o_target_protected
);
    wire logic none_sel;
    wire logic all_sel;
    wire logic top_sel;
    wire logic in_user_range;
    wire logic in_fixed_range;

    // bit 0 only distinguishes the all-ones value
    assign none_sel = (i_protect_start_bits == PROTECT_NONE);
    assign all_sel = (i_protect_start_bits <= PROTECT_ALL_MAX);
    assign top_sel = (i_protect_start_bits >= PROTECT_TOP_MIN) &&
        (i_protect_start_bits <= PROTECT_TOP_MAX);

    always_comb begin
        if (all_sel) begin
            o_start = 16'h0000;
        end else if (top_sel || none_sel) begin
            o_start = ALWAYS_PROT_START;
        end else begin
            o_start = {i_protect_start_bits[7:1], 9'h000};
        end
    end

    assign in_user_range = !none_sel && (i_target >= o_start);
    assign in_fixed_range = (i_target >= ALWAYS_PROT_START);
    // whole-array erase may clear the fixed top, not a user-protected range
    assign o_target_protected = i_mass ? (!none_sel && !top_sel) :
        (in_user_range || in_fixed_range);
endmodule : flpe_protect

// File: hw/flpe_target.sv
// target address latch from the first flash write after a selection
module flpe_target
    import flpe_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_select_any,
    input wire logic i_flash_wr,
    input wire logic [15:0] i_flash_addr,
    output logic o_latched,
    output logic [15:0] o_target,
    output logic o_in_row
);
    logic latched_reg;
    logic [15:0] target_reg;
    wire logic capture;

    assign capture = i_select_any && !latched_reg && i_flash_wr;
    assign o_in_row = latched_reg &&
        (i_flash_addr[15:ROW_LSB] == target_reg[15:ROW_LSB]);
    assign o_latched = latched_reg;
    assign o_target = target_reg;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            latched_reg <= 1'b0;
            target_reg <= TARGET_RESET;
        end else if (!i_select_any) begin
            // a fresh selection needs a fresh dummy write
            latched_reg <= 1'b0;
        end else if (capture) begin
            latched_reg <= 1'b1;
            target_reg <= i_flash_addr;
        end
    end
endmodule : flpe_target

// File: tb/flpe_props.sv
// port-level assertions for the flash program/erase/protect sequencer
module flpe_props
    import flpe_pkg::*;
#(
    parameter int PROG_GAP_CYCLES = PROG_MAX_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_flash_wr,
    input wire logic [15:0] i_flash_addr,
    input wire logic [7:0] i_flash_wdata,
    input wire logic o_pump_on,
    input wire logic o_array_hv,
    input wire logic o_prog_strobe,
    input wire logic [15:0] o_prog_addr,
    input wire logic [7:0] o_prog_data,
    input wire logic o_erase_run,
    input wire logic o_erase_mass,
    input wire logic [6:0] o_erase_page,
    input wire logic [7:0] o_erase_value
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    wire ctl_wr = i_reg_wr && (i_reg_addr == REG_CONTROL);

    a_pump_tracks_hv: assert property (o_pump_on == o_array_hv)
        else $error("pump and array high voltage differ");
    a_hv_from_write: assert property ($rose(o_pump_on) |->
        $past(ctl_wr && i_reg_wdata[CTL_HIGH_VOLTAGE_ENABLE_BIT]))
        else $error("high voltage rose without a control write");
    a_hv_clear_now: assert property (ctl_wr &&
        !i_reg_wdata[CTL_HIGH_VOLTAGE_ENABLE_BIT] |=> !o_pump_on)
        else $error("high voltage stayed after clear");
    a_erase_after_pump: assert property ($rose(o_erase_run) |->
        $past(o_pump_on))
        else $error("erase began without high voltage");
    a_erased_ones: assert property (o_erase_value ==
        (o_erase_run ? ERASED_BYTE : 8'h00))
        else $error("erase value wrong");
    a_vector_kept: assert property (o_erase_run && !o_erase_mass |->
        o_erase_page != VECTOR_PAGE)
        else $error("page erase hit vector page");
    a_prog_capture: assert property (o_prog_strobe |->
        $past(i_flash_wr) && o_pump_on &&
        o_prog_addr == $past(i_flash_addr) &&
        o_prog_data == $past(i_flash_wdata))
        else $error("programmed byte not the written one");
    a_rdata_quiet: assert property (!$past(i_reg_rd) |->
        o_reg_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule : flpe_props

bind flpe_top flpe_props #(.PROG_GAP_CYCLES(PROG_GAP_CYCLES)) u_props (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_flash_wr(i_flash_wr),
    .i_flash_addr(i_flash_addr), .i_flash_wdata(i_flash_wdata),
    .o_pump_on(o_pump_on), .o_array_hv(o_array_hv),
    .o_prog_strobe(o_prog_strobe), .o_prog_addr(o_prog_addr),
    .o_prog_data(o_prog_data), .o_erase_run(o_erase_run),
    .o_erase_mass(o_erase_mass), .o_erase_page(o_erase_page),
    .o_erase_value(o_erase_value)
);

// File: tb/tb_top.sv
// self-checking bench for the flash program/erase/protect sequencer
module tb_top
    import flpe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // short gap keeps the overrun check cheap
    localparam int GAP = 20;
    // protect value, target, expected protected flag
    localparam logic [24:0] PT [12] = '{
        {8'h09, 16'h0860, 1'h1}, {8'h0A, 16'h09FF, 1'h0},
        {8'h0A, 16'h0A00, 1'h1}, {8'h0B, 16'h0A00, 1'h1},
        {8'hF8, 16'hF7FF, 1'h0}, {8'hF8, 16'hF800, 1'h1},
        {8'hFC, 16'hFFCE, 1'h0}, {8'hFC, 16'hFFCF, 1'h1},
        {8'hFE, 16'hFFCF, 1'h1}, {8'hFF, 16'hFFCF, 1'h1},
        {8'hFF, 16'hFFFF, 1'h1}, {8'hFF, 16'hFFCE, 1'h0}};
    logic i_clock = 1'h0, i_rst_n = 1'h0, i_reg_wr = 1'h0;
    logic i_reg_rd = 1'h0, i_flash_wr = 1'h0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
    logic [7:0] i_flash_wdata = 8'h00;
    logic [15:0] i_flash_addr = 16'h0000;
    logic [7:0] o_reg_rdata, o_prog_data, o_erase_value;
    logic o_pump_on, o_array_hv, o_prog_strobe, o_erase_run, o_erase_mass;
    logic [15:0] o_prog_addr;
    logic [6:0] o_erase_page;
    int err_total = 0;
    int n_compared = 0;

    flpe_top #(.PROG_GAP_CYCLES(GAP)) dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .i_flash_wr(i_flash_wr), .i_flash_addr(i_flash_addr),
        .i_flash_wdata(i_flash_wdata), .o_pump_on(o_pump_on),
        .o_array_hv(o_array_hv), .o_prog_strobe(o_prog_strobe),
        .o_prog_addr(o_prog_addr), .o_prog_data(o_prog_data),
        .o_erase_run(o_erase_run), .o_erase_mass(o_erase_mass),
        .o_erase_page(o_erase_page), .o_erase_value(o_erase_value));

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'h1;
        @(posedge i_clock);
        i_reg_wr <= 1'h0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_rd <= 1'h1;
        @(posedge i_clock);
        i_reg_rd <= 1'h0;
        #1;
        chk(o_reg_rdata, e);
    endtask : rd

    task automatic fw(input logic [15:0] a, input logic [7:0] d,
            input logic s);
        @(posedge i_clock);
        i_flash_addr <= a;
        i_flash_wdata <= d;
        i_flash_wr <= 1'h1;
        @(posedge i_clock);
        i_flash_wr <= 1'h0;
        #1;
        chk(o_prog_strobe, s);
        if (s) begin
            chk(o_prog_addr, a);
            chk(o_prog_data, d);
        end
    endtask : fw

    initial begin
        forever #2.5 i_clock = ~i_clock;
    end

    initial begin
        repeat (50000) @(posedge i_clock);
        err_total++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge i_clock);
        i_rst_n <= 1'h1;
        // reset protect value guards target 0000, seen live in status
        for (int a = 0; a < 6; a++) rd(8'(a), (a == 2) ? 8'h02 : 8'h00);
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        wr(REG_CONTROL, 8'hF0);
        rd(REG_CONTROL, 8'h00);
        // reset protect value guards the whole array
        wr(REG_CONTROL, 8'h02);
        fw(16'h1000, 8'h00, 1'h0);
        wr(REG_CONTROL, 8'h0A);
        chk(o_pump_on, 1'h0);
        rd(REG_CONTROL, 8'h02);
        rd(REG_STATUS, 8'h07);
        wr(REG_STATUS, 8'h04);
        rd(REG_STATUS, 8'h03);
        wr(REG_CONTROL, 8'h03);
        rd(REG_CONTROL, 8'h02);
        rd(REG_STATUS, 8'h13);
        wr(REG_CONTROL, 8'h00);
        wr(REG_STATUS, 8'h10);
        rd(REG_STATUS, 8'h02);
        foreach (PT[i]) begin
            wr(REG_PROTECT, PT[i][24:17]);
            wr(REG_CONTROL, 8'h01);
            fw(PT[i][16:1], 8'h00, 1'h0);
            rd(REG_STATUS, {6'h00, PT[i][0], 1'h1});
            wr(REG_CONTROL, 8'h00);
        end
        wr(REG_PROTECT, PROTECT_NONE);
        rd(REG_PROTECT, PROTECT_NONE);
        wr(REG_CONTROL, 8'h01);
        fw(16'h1040, 8'h11, 1'h0);
        wr(REG_CONTROL, 8'h09);
        chk(o_pump_on, 1'h1);
        fw(16'h107F, 8'hA5, 1'h1);
        fw(16'h1080, 8'h5A, 1'h0);
        fw(16'h1000, 8'h5A, 1'h0);
        rd(REG_TARGET_HI, 8'h10);
        rd(REG_TARGET_LO, 8'h40);
        tick(GAP + 5);
        rd(REG_STATUS, 8'h09);
        wr(REG_CONTROL, 8'h08);
        chk(o_pump_on, 1'h1);
        wr(REG_CONTROL, 8'h00);
        chk(o_pump_on, 1'h0);
        wr(REG_STATUS, 8'h08);
        rd(REG_STATUS, 8'h00);
        // switching straight from program must drop the row latched for it
        wr(REG_CONTROL, 8'h01);
        fw(16'h1040, 8'h00, 1'h0);
        wr(REG_CONTROL, 8'h02);
        fw(16'h1234, 8'h00, 1'h0);
        wr(REG_CONTROL, 8'h0A);
        tick(1);
        chk(o_erase_run, 1'h1);
        chk(o_erase_mass, 1'h0);
        chk(o_erase_page, 7'h09);
        chk(o_erase_value, ERASED_BYTE);
        wr(REG_CONTROL, 8'h08);
        tick(1);
        chk(o_erase_run, 1'h0);
        wr(REG_CONTROL, 8'h00);
        // vector page starts below the top guard, so only the erase rule stops it
        wr(REG_CONTROL, 8'h02);
        fw(16'hFE00, 8'h00, 1'h0);
        wr(REG_CONTROL, 8'h0A);
        tick(3);
        chk(o_erase_run, 1'h0);
        wr(REG_CONTROL, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(REG_PROTECT, i ? 8'h0A : PROTECT_TOP_MIN);
            wr(REG_CONTROL, 8'h06);
            fw(16'hFFF0, 8'h00, 1'h0);
            wr(REG_CONTROL, 8'h0E);
            tick(1);
            chk(o_erase_run, i ? 1'h0 : 1'h1);
            chk(o_erase_mass, 1'h1);
            rd(REG_CONTROL, i ? 8'h06 : 8'h0E);
            wr(REG_CONTROL, 8'h00);
        end
        // mass and high voltage in one write would skip the mass check
        wr(REG_PROTECT, 8'hF8);
        wr(REG_CONTROL, 8'h02);
        fw(16'h1000, 8'h00, 1'h0);
        wr(REG_CONTROL, 8'h0E);
        chk(o_pump_on, 1'h0);
        rd(REG_CONTROL, 8'h06);
        wr(REG_CONTROL, 8'h00);
        // second reset in mid-run
        @(posedge i_clock);
        i_rst_n <= 1'h0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'h1;
        rd(REG_CONTROL, 8'h00);
        rd(REG_PROTECT, PROTECT_RESET);
        rd(REG_STATUS, 8'h02);
        finish_test();
    end
endmodule : tb_top
